// >>> rtl/sbs_defs.svh
`ifndef SBS_DEFS_SVH
`define SBS_DEFS_SVH

// register offsets (word index = byte address / 4)
`define SBS_ADDR_CTRL      8'h00
`define SBS_ADDR_STATUS    8'h04
`define SBS_ADDR_INDEX     8'h08
`define SBS_ADDR_KIND      8'h0c
`define SBS_ADDR_VALUE     8'h10
`define SBS_ADDR_REF       8'h14
`define SBS_ADDR_OUTS_LO   8'h18
`define SBS_ADDR_CAPTURE   8'h1c

// control fields
`define SBS_CTRL_ENABLE    0
`define SBS_CTRL_AUTO      1
`define SBS_CTRL_GO        2
`define SBS_CTRL_CLEAR     3

// kind register fields
`define SBS_KIND_LSB       0
`define SBS_KIND_MSB       3
`define SBS_KIND_MEMBER    4

// timing
`define SBS_CLOCK_HZ       10000000
`define SBS_TICK_S_NUM     1
`define SBS_TICK_S_DEN     10
`define SBS_TICK_CYCLES    (`SBS_CLOCK_HZ * `SBS_TICK_S_NUM / `SBS_TICK_S_DEN)

`endif

// >>> rtl/sbs_pkg.sv
package sbs_pkg;

    typedef enum logic [3:0] {
        SBS_OFF      = 4'h0,
        SBS_GROSS    = 4'h1,
        SBS_NET      = 4'h2,
        SBS_NGROSS   = 4'h3,
        SBS_NNET     = 4'h4,
        SBS_TOTAL    = 4'h5,
        SBS_SLOPE    = 4'h6,
        SBS_ABOVE    = 4'h7,
        SBS_BELOW    = 4'h8,
        SBS_PCT_TGT  = 4'h9,
        SBS_PCT_CAP  = 4'ha,
        SBS_PAUSE    = 4'hb,
        SBS_DELAY    = 4'hc,
        SBS_STILL    = 4'hd
    } sbs_kind_t;

    typedef enum logic [2:0] {
        SBS_IDLE     = 3'h0,
        SBS_PICK     = 3'h1,
        SBS_RUN      = 3'h2,
        SBS_NEXT     = 3'h3,
        SBS_HOLD     = 3'h4
    } sbs_state_t;

    typedef struct packed {
        logic signed [31:0] gross;
        logic signed [31:0] net;
        logic signed [31:0] total;
        logic signed [31:0] slope;
        logic               still;
        logic               update;
    } sbs_scale_t;

    typedef struct packed {
        logic        din;
        logic        serial;
        logic        softkey;
        logic        prog_call;
    } sbs_go_t;

endpackage

// >>> rtl/sbs_sequencer.sv
`timescale 1ns/100ps
`include "sbs_defs.svh"
// How it works
// - one hundred configurable setpoints with outputs
// - weight targets in primary units only
// - continuous setpoints re-evaluated each update
// - continuous outputs follow their condition
// - batch steps run one at a time
// - batch output active until met, latched
// - mode selects auto repeat or manual start
// - start from four request sources or the control go bit
// - dual kinds join batch via member flag
// - batch-only kinds join without member flag
// - off kind never acts nor drives
// - gross and net use positive targets
// - negative kinds use negated targets
// - total kind compares accumulated total
// - slope kind compares rate of change
// - offset kinds add or subtract reference target
// - percent kind scales reference target
// - captured kind scales reference capture
// - pause holds until new start request
// - delay counts value in tenth seconds
// - still step waits for standstill
module sbs_sequencer #(
    parameter int N_SP       = 100,
    parameter int TICK_CYCLES = `SBS_TICK_CYCLES
) (
    // clock and reset
    input  wire logic                clock,
    input  wire logic                resetn,
    // register port
    input  wire logic [7:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_write,
    input  wire logic                reg_read,
    output logic [31:0]              reg_rdata,
    // scale measurement
    input  wire sbs_pkg::sbs_scale_t scale,
    // start request sources
    input  wire sbs_pkg::sbs_go_t    go_src,
    // equipment outputs
    output logic [N_SP-1:0]          sp_out,
    output logic                     batch_busy
);

    localparam int IW = $clog2(N_SP);

    // ------------------------------------------------------------
    // reset and pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sync;
    logic       rst_n;
    logic [1:0] din_sync;
    logic       din_last;
    logic [1:0] still_sync;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            din_sync   <= 2'h0;
            din_last   <= 1'b0;
            still_sync <= 2'h0;
        end else begin
            din_sync   <= {din_sync[0], go_src.din};
            din_last   <= din_sync[1];
            still_sync <= {still_sync[0], scale.still};
        end
    end

    // ------------------------------------------------------------
    // setpoint table
    // ------------------------------------------------------------
    // hundred setpoint table
    sbs_pkg::sbs_kind_t kind_tab [N_SP];
    logic               member   [N_SP];
    logic signed [31:0] value    [N_SP];
    logic [IW-1:0]      ref_tab  [N_SP];
    logic signed [31:0] capture  [N_SP];

    logic          mode_on;
    logic          mode_auto;
    logic [IW-1:0] sel;
    logic [IW-1:0] step;
    logic          clear_req;

    wire sel_ok = 32'(sel) < N_SP;
    wire wr_ctrl = reg_write && reg_addr == `SBS_ADDR_CTRL;
    wire wr_kind = reg_write && reg_addr == `SBS_ADDR_KIND && sel_ok;
    wire wr_val  = reg_write && reg_addr == `SBS_ADDR_VALUE && sel_ok;
    wire wr_ref  = reg_write && reg_addr == `SBS_ADDR_REF && sel_ok;

    always_ff @(posedge clock) begin
        if (wr_kind) begin
            kind_tab[sel] <= sbs_pkg::sbs_kind_t'(reg_wdata[`SBS_KIND_MSB:`SBS_KIND_LSB]);
            member[sel]   <= reg_wdata[`SBS_KIND_MEMBER];
        end
        if (wr_val) begin
            value[sel] <= reg_wdata;
        end
        if (wr_ref) begin
            ref_tab[sel] <= reg_wdata[IW-1:0];
        end
    end

    // ------------------------------------------------------------
    // condition evaluation, one setpoint per cycle
    // ------------------------------------------------------------
    logic [IW-1:0] scan;
    wire  [IW-1:0] eval_ix;
    sbs_pkg::sbs_kind_t ek;
    logic signed [31:0] ev, rv, rc, tgt, meas;
    logic signed [63:0] pct;
    logic               met, is_batch_only, in_batch;
    sbs_pkg::sbs_kind_t rk;

    assign eval_ix = scan;

    always_comb begin
        ek   = kind_tab[eval_ix];
        ev   = value[eval_ix];
        rk   = kind_tab[ref_tab[eval_ix]];
        rv   = value[ref_tab[eval_ix]];
        rc   = capture[ref_tab[eval_ix]];
        pct  = 64'sd0;
        tgt  = ev;
        meas = scale.gross;
        case (ek)
            sbs_pkg::SBS_GROSS:   meas = scale.gross;
            sbs_pkg::SBS_NET:     meas = scale.net;
            sbs_pkg::SBS_NGROSS:  tgt  = -ev;
            sbs_pkg::SBS_NNET: begin
                tgt  = -ev;
                meas = scale.net;
            end
            sbs_pkg::SBS_TOTAL:   meas = scale.total;
            sbs_pkg::SBS_SLOPE:   meas = scale.slope;
            sbs_pkg::SBS_ABOVE:   tgt  = rv + ev;
            sbs_pkg::SBS_BELOW:   tgt  = rv - ev;
            sbs_pkg::SBS_PCT_TGT: begin
                pct = (64'(rv) * 64'(ev)) / 64'sd100;
                tgt = pct[31:0];
            end
            sbs_pkg::SBS_PCT_CAP: begin
                pct = (64'(rc) * 64'(ev)) / 64'sd100;
                tgt = pct[31:0];
            end
            default:              tgt  = ev;
        endcase
        if (ek == sbs_pkg::SBS_ABOVE || ek == sbs_pkg::SBS_BELOW ||
            ek == sbs_pkg::SBS_PCT_TGT || ek == sbs_pkg::SBS_PCT_CAP) begin
            meas = (rk == sbs_pkg::SBS_NET || rk == sbs_pkg::SBS_NNET) ? scale.net : scale.gross;
        end
        met = (ek == sbs_pkg::SBS_NGROSS || ek == sbs_pkg::SBS_NNET) ? (meas <= tgt)
                                                                   : (meas >= tgt);
        is_batch_only = ek == sbs_pkg::SBS_PAUSE || ek == sbs_pkg::SBS_DELAY ||
                        ek == sbs_pkg::SBS_STILL;
        in_batch = mode_on && (is_batch_only || (member[eval_ix] && ek != sbs_pkg::SBS_OFF));
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    sbs_pkg::sbs_state_t state;
    logic [31:0]         tick_cnt;
    logic [31:0]         delay_cnt;
    logic                go_any, go_pend;
    logic                latched;

    // four start sources and the control go bit
    // pin start acts on its rising edge only, a held level starts one run
    assign go_any = (din_sync[1] & ~din_last) | go_src.serial | go_src.softkey | go_src.prog_call |
                    (wr_ctrl & reg_wdata[`SBS_CTRL_GO]);

    wire tick = tick_cnt == 32'(TICK_CYCLES - 1);
    wire cur_batch_only = kind_tab[step] == sbs_pkg::SBS_PAUSE ||
                          kind_tab[step] == sbs_pkg::SBS_DELAY ||
                          kind_tab[step] == sbs_pkg::SBS_STILL;
    wire cur_member = mode_on && (cur_batch_only ||
                      (member[step] && kind_tab[step] != sbs_pkg::SBS_OFF));
    wire last_step = 32'(step) == N_SP - 1;
    wire scanning_step = eval_ix == step;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_on   <= 1'b0;
            mode_auto <= 1'b0;
            sel       <= '0;
            scan      <= '0;
            tick_cnt  <= 32'h0;
        end else begin
            scan     <= (32'(scan) == N_SP - 1) ? '0 : scan + 1'b1;
            tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
            if (wr_ctrl) begin
                mode_on   <= reg_wdata[`SBS_CTRL_ENABLE];
                mode_auto <= reg_wdata[`SBS_CTRL_AUTO];
            end
            if (reg_write && reg_addr == `SBS_ADDR_INDEX) begin
                sel <= reg_wdata[IW-1:0];
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state     <= sbs_pkg::SBS_IDLE;
            step      <= '0;
            delay_cnt <= 32'h0;
            go_pend   <= 1'b0;
            latched   <= 1'b0;
        end else begin
            // consumed in idle and pause, so a resume does not restart the next run
            go_pend <= (state == sbs_pkg::SBS_IDLE || state == sbs_pkg::SBS_HOLD) ? 1'b0
                       : (go_pend | go_any);
            case (state)
                sbs_pkg::SBS_IDLE: begin
                    step    <= '0;
                    latched <= 1'b0;
                    if (mode_on && (mode_auto || go_pend || go_any)) begin
                        state <= sbs_pkg::SBS_PICK;
                    end
                end
                sbs_pkg::SBS_PICK: begin
                    if (!mode_on) begin
                        state <= sbs_pkg::SBS_IDLE;
                    end else if (cur_member) begin
                        delay_cnt <= 32'(value[step]);
                        state     <= sbs_pkg::SBS_RUN;
                    end else begin
                        state <= sbs_pkg::SBS_NEXT;
                    end
                end
                sbs_pkg::SBS_RUN: begin
                    case (kind_tab[step])
                        sbs_pkg::SBS_PAUSE: state <= sbs_pkg::SBS_HOLD;
                        sbs_pkg::SBS_DELAY: begin
                            if (delay_cnt == 32'h0) begin
                                state <= sbs_pkg::SBS_NEXT;
                            end else if (tick) begin
                                delay_cnt <= delay_cnt - 32'h1;
                            end
                        end
                        sbs_pkg::SBS_STILL: begin
                            if (still_sync[1]) begin
                                state <= sbs_pkg::SBS_NEXT;
                            end
                        end
                        default: begin
                            if (scanning_step && scale.update && met) begin
                                state <= sbs_pkg::SBS_NEXT;
                            end
                        end
                    endcase
                    if (!mode_on) begin
                        state <= sbs_pkg::SBS_IDLE;
                    end
                end
                sbs_pkg::SBS_HOLD: begin
                    if (go_any) begin
                        state <= sbs_pkg::SBS_NEXT;
                    end
                end
                sbs_pkg::SBS_NEXT: begin
                    if (last_step) begin
                        step  <= '0;
                        state <= sbs_pkg::SBS_IDLE;
                    end else begin
                        step  <= step + 1'b1;
                        state <= sbs_pkg::SBS_PICK;
                    end
                end
                default: state <= sbs_pkg::SBS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs and captures
    // ------------------------------------------------------------
    wire in_seq = state != sbs_pkg::SBS_IDLE;
    logic [N_SP-1:0] done;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sp_out     <= '0;
            done       <= '0;
            batch_busy <= 1'b0;
        end else begin
            batch_busy <= in_seq;
            if (!in_seq) begin
                done <= '0;
            end
            if (ek == sbs_pkg::SBS_OFF || is_batch_only) begin
                sp_out[eval_ix] <= 1'b0;
            end else if (in_batch) begin
                if (!in_seq || done[eval_ix]) begin
                    sp_out[eval_ix] <= sp_out[eval_ix] & in_seq;
                end else if (eval_ix == step && state == sbs_pkg::SBS_RUN) begin
                    sp_out[eval_ix] <= !(scale.update && met);
                    done[eval_ix]   <= scale.update && met;
                end
            end else if (scale.update) begin
                sp_out[eval_ix] <= met;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (scale.update && in_batch && eval_ix == step && state == sbs_pkg::SBS_RUN && met) begin
            capture[eval_ix] <= meas;
        end
    end

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    wire [31:0] rd_mux =
        reg_addr == `SBS_ADDR_CTRL    ? {30'h0, mode_auto, mode_on} :
        reg_addr == `SBS_ADDR_STATUS  ? {21'h0, state, 1'b0, step} :
        reg_addr == `SBS_ADDR_INDEX   ? 32'(sel) :
        reg_addr == `SBS_ADDR_KIND    ? {27'h0, member[sel], kind_tab[sel]} :
        reg_addr == `SBS_ADDR_VALUE   ? value[sel] :
        reg_addr == `SBS_ADDR_REF     ? 32'(ref_tab[sel]) :
        reg_addr == `SBS_ADDR_OUTS_LO ? sp_out[31:0] :
        reg_addr == `SBS_ADDR_CAPTURE ? capture[sel] : 32'h0;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= reg_read ? rd_mux : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_off_quiet;
        @(posedge clock) disable iff (!rst_n)
        (ek == sbs_pkg::SBS_OFF) |=> !sp_out[$past(eval_ix)];
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("off setpoint drove output");

    property p_pause_hold;
        @(posedge clock) disable iff (!rst_n)
        (state == sbs_pkg::SBS_HOLD && !go_any) |=> state == sbs_pkg::SBS_HOLD;
    endproperty
    a_pause_hold: assert property (p_pause_hold) else $error("pause left without start");

    property p_idle_mode;
        @(posedge clock) disable iff (!rst_n)
        (state == sbs_pkg::SBS_IDLE && !mode_on) |=> state == sbs_pkg::SBS_IDLE;
    endproperty
    a_idle_mode: assert property (p_idle_mode) else $error("batch ran while disabled");

    property p_auto_go;
        @(posedge clock) disable iff (!rst_n)
        (state == sbs_pkg::SBS_IDLE && mode_on && mode_auto) |=> state == sbs_pkg::SBS_PICK;
    endproperty
    a_auto_go: assert property (p_auto_go) else $error("auto mode did not restart");

    property p_one_step;
        @(posedge clock) disable iff (!rst_n)
        (state == sbs_pkg::SBS_NEXT && !last_step) |=> step == $past(step) + 1'b1;
    endproperty
    a_one_step: assert property (p_one_step) else $error("step skipped");

    property p_busy;
        @(posedge clock) disable iff (!rst_n)
        in_seq |=> batch_busy;
    endproperty
    a_busy: assert property (p_busy) else $error("busy flag missing");

    property p_still;
        @(posedge clock) disable iff (!rst_n)
        (state == sbs_pkg::SBS_RUN && kind_tab[step] == sbs_pkg::SBS_STILL && !still_sync[1]
         && mode_on) |=> state == sbs_pkg::SBS_RUN;
    endproperty
    a_still: assert property (p_still) else $error("advanced while moving");

    property p_delay;
        @(posedge clock) disable iff (!rst_n)
        (state == sbs_pkg::SBS_RUN && kind_tab[step] == sbs_pkg::SBS_DELAY && delay_cnt != 0
         && mode_on) |=> state == sbs_pkg::SBS_RUN;
    endproperty
    a_delay: assert property (p_delay) else $error("delay ended early");

endmodule

// >>> tb/sbs_scale_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// scale measurement source
// ----------------------------------------
module sbs_scale_model (
    // clock
    input  wire logic           clock,
    // measurement towards the indicator
    output sbs_pkg::sbs_scale_t scale
);
    initial begin
        scale = '0;
    end

    // update held over a full scan so every slot sees it
    task automatic measure(input logic signed [31:0] g, input logic signed [31:0] n,
                           input logic signed [31:0] t, input logic signed [31:0] s);
        @(posedge clock);
        scale.gross  <= g;
        scale.net    <= n;
        scale.total  <= t;
        scale.slope  <= s;
        scale.update <= 1'b1;
        repeat (110) @(posedge clock);
        scale.update <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
    endtask

    task automatic set_still(input logic v);
        @(posedge clock);
        scale.still <= v;
    endtask
endmodule

// >>> tb/setpoint_batch_sequencer_tb.sv
`timescale 1ns/100ps
`include "sbs_defs.svh"
module setpoint_batch_sequencer_tb;
    logic                clock;
    logic                resetn;
    logic [7:0]          reg_addr;
    logic [31:0]         reg_wdata;
    logic                reg_write;
    logic                reg_read;
    logic [31:0]         reg_rdata;
    sbs_pkg::sbs_scale_t scale;
    sbs_pkg::sbs_go_t    go_src;
    logic [99:0]         sp_out;
    logic                batch_busy;
    logic [31:0]         d;
    int                  n;
    int                  bad_count;
    int                  cmp_count;

    sbs_sequencer #(.N_SP(100), .TICK_CYCLES(10)) uut (
        .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .scale(scale), .go_src(go_src), .sp_out(sp_out), .batch_busy(batch_busy));

    sbs_scale_model model (.clock(clock), .scale(scale));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic sp_cfg(input int i, input sbs_pkg::sbs_kind_t k, input logic m,
                          input int v, input int r);
        wr(`SBS_ADDR_INDEX, i);
        wr(`SBS_ADDR_KIND, {27'h0, m, k});
        wr(`SBS_ADDR_VALUE, v);
        wr(`SBS_ADDR_REF, r);
    endtask

    // reads status until the step matches or the read limit runs out
    task automatic poll(input int s, input int lim, output int cnt);
        logic [31:0] v;
        cnt = 0;
        rd(`SBS_ADDR_STATUS, v);
        while (v[6:0] !== s[6:0] && cnt < lim) begin
            cnt++;
            rd(`SBS_ADDR_STATUS, v);
        end
    endtask

    task automatic pulse(input logic [3:0] src);
        @(posedge clock);
        go_src <= sbs_pkg::sbs_go_t'(src);
        repeat (src[3] ? 3 : 1) @(posedge clock);
        go_src <= '0;
    endtask

    task automatic wait_idle();
        int c;
        c = 0;
        while (batch_busy !== 1'b0 && c < 400) begin
            @(posedge clock);
            c++;
        end
        #1;
    endtask

    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clock);
        bad_count++;
        $display("ERROR watchdog expected done seen hang");
        finish_test();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        resetn    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0;
        reg_write = 1'b0;
        reg_read  = 1'b0;
        go_src    = '0;
        bad_count = 0;
        cmp_count = 0;
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        repeat (4) @(posedge clock);
        check("busy reset", 32'h0, {31'h0, batch_busy});
        rd(8'h20, d);
        check("unmapped", 32'h0, d);
        for (int i = 0; i < 100; i++) begin
            sp_cfg(i, sbs_pkg::SBS_OFF, 1'b0, 0, 0);
        end
        // continuous kinds, one per slot
        for (int k = 1; k <= 6; k++) begin
            sp_cfg(k, sbs_pkg::sbs_kind_t'(k), 1'b0, 100, 0);
        end
        sp_cfg(7, sbs_pkg::SBS_ABOVE, 1'b0, 50, 1);
        sp_cfg(8, sbs_pkg::SBS_PCT_TGT, 1'b0, 50, 1);
        sp_cfg(9, sbs_pkg::SBS_BELOW, 1'b0, 30, 1);
        model.measure(100, 100, 100, 100);
        check("cont a", 32'h366, sp_out[31:0]);
        rd(`SBS_ADDR_OUTS_LO, d);
        check("outs reg", 32'h366, d);
        model.measure(-100, -100, 99, 99);
        check("cont b", 32'h18, sp_out[31:0]);
        model.measure(150, 0, 0, 0);
        check("cont c", 32'h382, sp_out[31:0]);
        check("off kinds", 32'h0, {31'h0, |sp_out[99:10]});
        // batch: two weight steps around delay, standstill and pause
        sp_cfg(0, sbs_pkg::SBS_GROSS, 1'b1, 100, 0);
        sp_cfg(1, sbs_pkg::SBS_DELAY, 1'b0, 3, 0);
        sp_cfg(2, sbs_pkg::SBS_STILL, 1'b0, 0, 0);
        sp_cfg(3, sbs_pkg::SBS_PAUSE, 1'b0, 0, 0);
        sp_cfg(4, sbs_pkg::SBS_NET, 1'b1, 10, 0);
        sp_cfg(5, sbs_pkg::SBS_GROSS, 1'b0, 100, 0);
        sp_cfg(6, sbs_pkg::SBS_PCT_CAP, 1'b0, 50, 0);
        for (int i = 7; i < 10; i++) begin
            sp_cfg(i, sbs_pkg::SBS_OFF, 1'b0, 0, 0);
        end
        model.measure(0, 0, 0, 0);
        wr(`SBS_ADDR_CTRL, 32'h1);
        repeat (20) @(posedge clock);
        check("manual idle", 32'h0, {31'h0, batch_busy});
        pulse(4'b0100);
        repeat (10) @(posedge clock);
        check("busy serial", 32'h1, {31'h0, batch_busy});
        model.measure(0, 0, 0, 0);
        check("step active", 32'h1, {31'h0, sp_out[0]});
        check("one at a time", 32'h0, {31'h0, sp_out[4]});
        fork
            model.measure(150, 0, 0, 0);
            begin
                poll(1, 100, n);
                poll(2, 100, n);
            end
        join
        check("delay span", 32'h1, {31'h0, n >= 10 && n <= 20});
        check("met off", 32'h0, {31'h0, sp_out[0]});
        check("cont in batch", 32'h1, {31'h0, sp_out[5]});
        model.measure(0, 0, 0, 0);
        check("latched", 32'h0, {31'h0, sp_out[0]});
        check("cont follows", 32'h0, {31'h0, sp_out[5]});
        wr(`SBS_ADDR_INDEX, 0);
        rd(`SBS_ADDR_CAPTURE, d);
        check("capture", 32'd150, d);
        poll(3, 50, n);
        check("await still", 32'd50, n);
        model.set_still(1'b1);
        poll(3, 50, n);
        check("still seen", 32'h1, {31'h0, n < 50});
        poll(4, 50, n);
        check("pause holds", 32'd50, n);
        pulse(4'b0010);
        poll(4, 50, n);
        check("pause resumed", 32'h1, {31'h0, n < 50});
        model.measure(0, 0, 0, 0);
        check("last step", 32'h1, {31'h0, sp_out[4]});
        model.measure(0, 20, 0, 0);
        wait_idle();
        repeat (50) @(posedge clock);
        check("manual end", 32'h0, {31'h0, batch_busy});
        // second run from the pin, pause left with a program call
        pulse(4'b1000);
        repeat (10) @(posedge clock);
        check("busy din", 32'h1, {31'h0, batch_busy});
        model.measure(0, 0, 0, 0);
        check("rerun active", 32'h1, {31'h0, sp_out[0]});
        check("capt low", 32'h0, {31'h0, sp_out[6]});
        model.measure(150, 20, 0, 0);
        check("capt high", 32'h1, {31'h0, sp_out[6]});
        poll(3, 100, n);
        pulse(4'b0001);
        model.measure(0, 20, 0, 0);
        wait_idle();
        check("second end", 32'h0, {31'h0, batch_busy});
        // automatic repeat without start requests
        sp_cfg(3, sbs_pkg::SBS_OFF, 1'b0, 0, 0);
        sp_cfg(4, sbs_pkg::SBS_OFF, 1'b0, 0, 0);
        wr(`SBS_ADDR_CTRL, 32'h3);
        repeat (10) @(posedge clock);
        check("auto start", 32'h1, {31'h0, batch_busy});
        fork
            model.measure(150, 0, 0, 0);
            poll(2, 200, n);
        join
        poll(0, 300, n);
        check("auto wrap", 32'h1, {31'h0, n < 300});
        repeat (3) @(posedge clock);
        #1;
        check("auto busy", 32'h1, {31'h0, batch_busy});
        finish_test();
    end
endmodule
